// ==== sscr_pkg.sv ====
// What this block does
// - Regulator bit 0/4: off with output pulled down, or on with pull-down released.
// - Voltage bit 1/5 selects 1.8 V when 0, 2.95 V when 1.
// - State 00: pull-downs if regulator off, totem-pole low if regulator on.
// - State 01: isolated, pull-downs off, card outputs latched and driven.
// - State 11: active, pull-downs off, card outputs follow host inputs.
// - State 10 behaves as powered with pull-downs, like 00 with regulator on.
// - State bits and regulator bits are stored independently.
// - Regulator bits affect reported slot status bits, not stored state bits.
// - Battery debounce register holds 8-bit reload; zero disables debouncing.
// - Shutdown debounce register holds 8-bit reload; zero disables debouncing.
// - Writing a debounce register restarts a running counter with new value.
// - New debounce value takes effect within one timing-clock tick, except for a count that starts on the tick the write lands on.
// - Clock control bit 7 picks internal (0) or external (1) timing clock.
// - Slot status is 00 with regulator off; with it on, state, 00 showing as 10.
// - Battery debounce expiry updates the separate battery-not-present output, not the slot status.
package sscr_pkg;
    localparam logic [7:0] SSCR_ADDR_SLOT = 8'h08;
    localparam logic [7:0] SSCR_ADDR_BATDB = 8'h0A;
    localparam logic [7:0] SSCR_ADDR_SDNDB = 8'h0B;
    localparam logic [7:0] SSCR_ADDR_CLKSEL = 8'h0D;
    localparam logic [7:0] SSCR_RST_SLOT = 8'h00;
    localparam logic [7:0] SSCR_RST_DB = 8'h04;
    localparam logic [7:0] SSCR_RST_CLKSEL = 8'h00;
    localparam int SSCR_CLKSEL_BIT = 7;
    localparam logic [1:0] SSCR_ST_DOWN = 2'h0;
    localparam logic [1:0] SSCR_ST_ISO = 2'h1;
    localparam logic [1:0] SSCR_ST_PWR = 2'h2;
    localparam logic [1:0] SSCR_ST_ACT = 2'h3;

    typedef struct packed {
        logic [1:0] state;
        logic vsel;
        logic reg_on;
    } sscr_slot_s;

    typedef struct packed {
        logic reg_en;
        logic reg_pulldown;
        logic vsel_hi;
        logic card_pulldown;
        logic card_drive;
        logic card_follow;
        logic [1:0] status;
    } sscr_slot_out_s;

    function automatic sscr_slot_out_s sscr_decode(input sscr_slot_s s);
        sscr_slot_out_s o;
        o.reg_en = s.reg_on;
        o.reg_pulldown = ~s.reg_on;
        o.vsel_hi = s.vsel;
        // A powered slot left in state 00 reports as powered with pull-downs
        if (!s.reg_on) begin
            o.status = SSCR_ST_DOWN;
        end else if (s.state == SSCR_ST_DOWN) begin
            o.status = SSCR_ST_PWR;
        end else begin
            o.status = s.state;
        end
        o.card_pulldown = (o.status == SSCR_ST_DOWN) || (o.status == SSCR_ST_PWR);
        o.card_drive = (o.status != SSCR_ST_DOWN);
        o.card_follow = (o.status == SSCR_ST_ACT);
        return o;
    endfunction
endpackage

// ==== sscr_debounce.sv ====
`timescale 1ns/100ps
`default_nettype none
module sscr_debounce import sscr_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_raw,
    input wire logic [7:0] i_reload,
    input wire logic i_reload_wr,
    output logic o_level,
    output logic o_changed
);
    typedef struct packed {
        logic level;
        logic changed;
        logic busy;
        logic restart;
        logic [7:0] cnt;
    } sscr_db_s;

    sscr_db_s st_ff;
    sscr_db_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.changed = 1'b0;
        if (i_reload == 8'h00) begin
            nxt_st.busy = 1'b0;
            nxt_st.restart = 1'b0;
            if (i_raw != st_ff.level) begin
                nxt_st.level = i_raw;
                nxt_st.changed = 1'b1;
            end
        end else if (i_tick) begin
            nxt_st.restart = 1'b0;
            if (i_raw == st_ff.level) begin
                nxt_st.busy = 1'b0;
            end else if (!st_ff.busy || st_ff.restart) begin
                nxt_st.busy = 1'b1;
                nxt_st.cnt = i_reload - 8'h01;
                if (i_reload == 8'h01) begin
                    nxt_st.level = i_raw;
                    nxt_st.changed = 1'b1;
                    nxt_st.busy = 1'b0;
                end
            end else if (st_ff.cnt <= 8'h01) begin
                nxt_st.level = i_raw;
                nxt_st.changed = 1'b1;
                nxt_st.busy = 1'b0;
            end else begin
                nxt_st.cnt = st_ff.cnt - 8'h01;
            end
        end
        // Set after the tick branch so a write landing on a tick is not lost
        if (i_reload_wr && st_ff.busy) begin
            nxt_st.restart = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_level = st_ff.level;
    assign o_changed = st_ff.changed;

    chk_zero_bypass: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (i_reload == 8'h00 && i_raw != o_level) |=> o_level == $past(i_raw))
        else $error("zero reload did not bypass debounce");
    chk_hold_stable: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (!i_tick && i_reload != 8'h00) |=> $stable(o_level))
        else $error("level changed without a tick");
endmodule
`default_nettype wire

// ==== sscr_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module sscr_regs import sscr_pkg::*; #(
    parameter int SSCR_SYNC = 3
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_tick_int,
    input wire logic i_tick_ext,
    input wire logic i_battery_presence_input,
    input wire logic i_shutdown_input,
    output sscr_slot_out_s o_card_slot_one,
    output sscr_slot_out_s o_card_slot_two,
    output logic o_ext_clk_sel,
    output logic o_battery_not_present,
    output logic o_shutdown_level,
    output logic [3:0] o_slot_status
);
    typedef struct packed {
        sscr_slot_s slot_two;
        sscr_slot_s slot_one;
        logic [7:0] bat_db;
        logic [7:0] sdn_db;
        logic [7:0] clksel;
        logic [7:0] rdata;
        logic [2:0] tick_sync;
        logic [2:0] bat_sync;
        logic [2:0] sdn_sync;
        logic tick_last;
    } sscr_regs_s;

    sscr_regs_s st_ff;
    sscr_regs_s nxt_st;
    logic tick_pulse;
    logic bat_level;
    logic sdn_level;
    logic wr_slot;
    logic wr_bat;
    logic wr_sdn;
    logic wr_clk;
    logic bat_in_ok;
    logic sdn_in_ok;
    sscr_slot_out_s dec_one;
    sscr_slot_out_s dec_two;

    ////////////////////////////////////////////////////////////////////////////////
    assign wr_slot = i_wr_en && (i_addr == SSCR_ADDR_SLOT);
    assign wr_bat = i_wr_en && (i_addr == SSCR_ADDR_BATDB);
    assign wr_sdn = i_wr_en && (i_addr == SSCR_ADDR_SDNDB);
    assign wr_clk = i_wr_en && (i_addr == SSCR_ADDR_CLKSEL);
    // Pin levels count once the second and third stage agree
    assign bat_in_ok = st_ff.bat_sync[1] ~^ st_ff.bat_sync[2];
    assign sdn_in_ok = st_ff.sdn_sync[1] ~^ st_ff.sdn_sync[2];
    assign tick_pulse = (st_ff.tick_sync[1] == st_ff.tick_sync[2]) &&
        st_ff.tick_sync[2] && !st_ff.tick_last;
    assign dec_one = sscr_decode(st_ff.slot_one);
    assign dec_two = sscr_decode(st_ff.slot_two);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick_sync = {st_ff.tick_sync[1:0],
            st_ff.clksel[SSCR_CLKSEL_BIT] ? i_tick_ext : i_tick_int};
        nxt_st.bat_sync = {st_ff.bat_sync[1:0], i_battery_presence_input};
        nxt_st.sdn_sync = {st_ff.sdn_sync[1:0], i_shutdown_input};
        if (st_ff.tick_sync[1] == st_ff.tick_sync[2]) begin
            nxt_st.tick_last = st_ff.tick_sync[2];
        end
        if (wr_slot) begin
            // Both fields come from one byte but land in separate fields
            nxt_st.slot_one.reg_on = i_wdata[0];
            nxt_st.slot_one.vsel = i_wdata[1];
            nxt_st.slot_one.state = i_wdata[3:2];
            nxt_st.slot_two.reg_on = i_wdata[4];
            nxt_st.slot_two.vsel = i_wdata[5];
            nxt_st.slot_two.state = i_wdata[7:6];
        end
        if (wr_bat) begin
            nxt_st.bat_db = i_wdata;
        end
        if (wr_sdn) begin
            nxt_st.sdn_db = i_wdata;
        end
        if (wr_clk) begin
            nxt_st.clksel = i_wdata;
        end
        unique case (i_addr)
            SSCR_ADDR_SLOT: nxt_st.rdata = {st_ff.slot_two.state, st_ff.slot_two.vsel,
                st_ff.slot_two.reg_on, st_ff.slot_one.state, st_ff.slot_one.vsel,
                st_ff.slot_one.reg_on};
            SSCR_ADDR_BATDB: nxt_st.rdata = st_ff.bat_db;
            SSCR_ADDR_SDNDB: nxt_st.rdata = st_ff.sdn_db;
            SSCR_ADDR_CLKSEL: nxt_st.rdata = st_ff.clksel;
            default: nxt_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_ff <= '0;
            st_ff.slot_one <= SSCR_RST_SLOT[3:0];
            st_ff.slot_two <= SSCR_RST_SLOT[7:4];
            st_ff.bat_db <= SSCR_RST_DB;
            st_ff.sdn_db <= SSCR_RST_DB;
            st_ff.clksel <= SSCR_RST_CLKSEL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sscr_debounce u_bat_db (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_tick(tick_pulse),
        .i_raw(bat_in_ok ? st_ff.bat_sync[2] : bat_level),
        .i_reload(st_ff.bat_db),
        .i_reload_wr(wr_bat),
        .o_level(bat_level),
        .o_changed()
    );

    sscr_debounce u_sdn_db (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_tick(tick_pulse),
        .i_raw(sdn_in_ok ? st_ff.sdn_sync[2] : sdn_level),
        .i_reload(st_ff.sdn_db),
        .i_reload_wr(wr_sdn),
        .o_level(sdn_level),
        .o_changed()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Status is the decoded view; stored state bits stay untouched
    assign o_slot_status = {dec_two.status, dec_one.status};
    assign o_card_slot_one = dec_one;
    assign o_card_slot_two = dec_two;
    assign o_rdata = st_ff.rdata;
    assign o_ext_clk_sel = st_ff.clksel[SSCR_CLKSEL_BIT];
    // Low level on the presence input means the pack is gone
    assign o_battery_not_present = ~bat_level;
    assign o_shutdown_level = sdn_level;

    ////////////////////////////////////////////////////////////////////////////////
    chk_status_off: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !st_ff.slot_one.reg_on |-> dec_one.status == SSCR_ST_DOWN)
        else $error("slot one status not down with regulator off");
    chk_status_on: assert property (@(posedge i_core_clk) disable iff (i_reset)
        st_ff.slot_two.reg_on |-> dec_two.status == ((st_ff.slot_two.state == SSCR_ST_DOWN) ?
        SSCR_ST_PWR : st_ff.slot_two.state))
        else $error("slot two status does not mirror state");
    chk_reg_pull: assert property (@(posedge i_core_clk) disable iff (i_reset)
        dec_one.reg_en != dec_one.reg_pulldown)
        else $error("regulator and pull-down overlap");
    chk_slot_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_slot |=> st_ff.slot_one.state == $past(i_wdata[3:2]) &&
        st_ff.slot_two.reg_on == $past(i_wdata[4]))
        else $error("slot control write not stored");
    chk_vsel: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_slot |=> o_card_slot_two.vsel_hi == $past(i_wdata[5]))
        else $error("voltage select not applied");
    chk_state_ten: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (st_ff.slot_one.reg_on && st_ff.slot_one.state == SSCR_ST_PWR) |->
        dec_one.card_pulldown && dec_one.card_drive && !dec_one.card_follow)
        else $error("state 10 not powered with pull-downs");
    chk_active: assert property (@(posedge i_core_clk) disable iff (i_reset)
        dec_two.status == SSCR_ST_ACT |-> dec_two.card_follow && !dec_two.card_pulldown)
        else $error("active slot not following");
    chk_isolated: assert property (@(posedge i_core_clk) disable iff (i_reset)
        dec_one.status == SSCR_ST_ISO |->
        dec_one.card_drive && !dec_one.card_follow && !dec_one.card_pulldown)
        else $error("isolated slot not latched");
    chk_clk_sel: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_clk |=> o_ext_clk_sel == $past(i_wdata[SSCR_CLKSEL_BIT]))
        else $error("clock select not stored");
    cov_active: cover property (@(posedge i_core_clk) dec_one.status == SSCR_ST_ACT);
    cov_bat_gone: cover property (@(posedge i_core_clk) $rose(o_battery_not_present));
    cov_db_rewrite: cover property (@(posedge i_core_clk) wr_sdn ##1 tick_pulse);
endmodule
`default_nettype wire

// ==== sscr_clk_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module sscr_clk_partner (
    input wire logic i_run_ext,
    output logic o_tick_int,
    output logic o_tick_ext
);
    // Timing clocks scaled down to keep the run short; counts are in ticks
    // Internal source runs free; phase offset keeps edges off both core edges
    initial begin
        o_tick_int = 1'b0;
        #5;
        forever begin
            #650;
            o_tick_int = ~o_tick_int;
        end
    end
    // External source stands still until the host enables it
    initial begin
        o_tick_ext = 1'b0;
        #3;
        forever begin
            #980;
            if (i_run_ext) begin
                o_tick_ext = ~o_tick_ext;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb_sim_slot_control_registers.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_sim_slot_control_registers import sscr_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic bat = 1'b0;
    logic shutdown_input = 1'b0;
    logic run_ext = 1'b0;
    logic t_int;
    logic t_ext;
    sscr_slot_out_s s1;
    sscr_slot_out_s s2;
    logic [7:0] rdata;
    logic ext_sel;
    logic bnp;
    logic sdn_lvl;
    logic [3:0] status;
    int n_fail = 0;
    int n_checks = 0;

    always #20 clk = ~clk;

    sscr_regs i_dut (.i_core_clk(clk), .i_reset(rst), .i_wr_en(wr_en), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .i_tick_int(t_int), .i_tick_ext(t_ext),
        .i_battery_presence_input(bat), .i_shutdown_input(shutdown_input), .o_card_slot_one(s1),
        .o_card_slot_two(s2), .o_ext_clk_sel(ext_sel), .o_battery_not_present(bnp),
        .o_shutdown_level(sdn_lvl), .o_slot_status(status));
    sscr_clk_partner i_clk (.i_run_ext(run_ext), .o_tick_int(t_int), .o_tick_ext(t_ext));

    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Lands just after a rising internal tick so tick counts are known
    task align;
        int k;
        k = 0;
        while (t_int === 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        while (t_int === 1'b0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k >= 200) begin
            n_fail++;
            conclude();
        end
    endtask
    // Worked out independently of the package decode function
    function automatic logic [7:0] exp_slot(input logic [3:0] f);
        logic [1:0] st;
        st = f[0] ? ((f[3:2] == 2'h0) ? 2'h2 : f[3:2]) : 2'h0;
        return {f[0], ~f[0], f[1], (st == 2'h0) || (st == 2'h2), st != 2'h0, st == 2'h3, st};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("timeout");
        conclude();
    end

    initial begin
        logic [7:0] ra[5];
        logic [7:0] re[5];
        logic [7:0] v;
        logic [7:0] d;
        ra = '{8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h09};
        re = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wr(8'h09, 8'hFF);
        for (int k = 0; k < 5; k++) begin
            rd(ra[k], d);
            check("reset or unmapped", d, re[k]);
        end
        check("battery flag at reset", {7'h00, bnp}, 8'h01);
        $display("test reset done");
        // Every state code, including the forbidden one, in both slots
        for (int k = 0; k < 16; k++) begin
            v = {~k[3:0], k[3:0]};
            wr(8'h08, v);
            check("slot one", s1, exp_slot(v[3:0]));
            check("slot two", s2, exp_slot(v[7:4]));
            check("status", {4'h0, status}, ((exp_slot(v[7:4]) & 8'h03) << 2) |
                (exp_slot(v[3:0]) & 8'h03));
            rd(8'h08, d);
            check("slot readback", d, v);
        end
        $display("test slots done");
        wr(8'h0D, 8'h7F);
        rd(8'h0D, d);
        check("clock reg", d, 8'h7F);
        check("clock select", {7'h00, ext_sel}, 8'h00);
        $display("test clock reg done");
        align();
        bat <= 1'b1;
        cyc(114);
        check("battery early", {7'h00, bnp}, 8'h01);
        cyc(32);
        check("battery debounced", {7'h00, bnp}, 8'h00);
        align();
        shutdown_input <= 1'b1;
        cyc(64);
        shutdown_input <= 1'b0;
        cyc(160);
        check("shutdown glitch", {7'h00, sdn_lvl}, 8'h00);
        wr(8'h0B, 8'h00);
        shutdown_input <= 1'b1;
        cyc(8);
        check("shutdown no debounce", {7'h00, sdn_lvl}, 8'h01);
        $display("test debounce done");
        wr(8'h0B, 8'h08);
        align();
        shutdown_input <= 1'b0;
        cyc(80);
        wr(8'h0B, 8'h02);
        cyc(32);
        check("reload restart early", {7'h00, sdn_lvl}, 8'h01);
        cyc(96);
        check("reload restart", {7'h00, sdn_lvl}, 8'h00);
        $display("test reload done");
        wr(8'h0A, 8'h02);
        wr(8'h0D, 8'h80);
        check("external select", {7'h00, ext_sel}, 8'h01);
        bat <= 1'b0;
        cyc(160);
        check("external stopped", {7'h00, bnp}, 8'h00);
        run_ext <= 1'b1;
        cyc(200);
        check("external ticks", {7'h00, bnp}, 8'h01);
        $display("test external clock done");
        conclude();
    end
endmodule
`default_nettype wire
